// ==== rtl/aalu_pkg.sv ====
// Purpose: Shared constants and carriers for the add/AND execution slice
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: Phase counter runs one instruction per four system clocks
package aalu_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] AALU_TOP_ADD_LIT = 8'h0f;
  localparam logic [7:0] AALU_TOP_AND_LIT = 8'h0b;
  localparam logic [5:0] AALU_TOP6_ADD_FILE = 6'h09;
  localparam logic [5:0] AALU_TOP6_ADD_CARRY = 6'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AALU_DEST_BIT = 9;
  localparam int AALU_ACCESS_BIT = 8;

  // ----------------------------------------------------------------
  // Reset values and access bank number
  // ----------------------------------------------------------------
  localparam logic [7:0] AALU_ACC_RESET = 8'h00;
  localparam logic [1:0] AALU_PHASE_RESET = 2'h0;
  localparam logic [3:0] AALU_ACCESS_BANK = 4'h0;

  typedef enum logic [2:0] {
    AALU_OP_NONE,
    AALU_OP_ADD_LIT,
    AALU_OP_ADD_FILE,
    AALU_OP_ADD_CARRY,
    AALU_OP_AND_LIT
  } aalu_op_e;

  typedef enum {
    AALU_PH_DECODE,
    AALU_PH_READ,
    AALU_PH_PROCESS,
    AALU_PH_WRITE
  } aalu_phase_e;

  // Arithmetic flags seen by the slice
  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } aalu_flags_s;

  // Data memory write request
  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [7:0] data;
  } aalu_wr_s;

endpackage : aalu_pkg

// ==== rtl/aalu_slice.sv ====
// Purpose: Executes add-literal, add-to-file, add-with-carry and AND-literal
// Assumes: Memory read data is valid in the same clock that the read address is driven
// Notes: Instruction word is sampled in the decode phase only
`timescale 1ns/100ps

module aalu_slice
  import aalu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic [3:0] bank_select_value,
  input wire logic [7:0] mem_rdata,
  input wire aalu_flags_s flags_in,
  output aalu_flags_s flags_out,
  output logic flags_we,
  output logic [11:0] mem_raddr,
  output logic mem_re,
  output aalu_wr_s mem_wr,
  output logic [7:0] working_accumulator,
  output logic [1:0] phase
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic aalu_op_e decode_op(input logic [15:0] w);
    if (w[15:8] == AALU_TOP_ADD_LIT) return AALU_OP_ADD_LIT;
    if (w[15:8] == AALU_TOP_AND_LIT) return AALU_OP_AND_LIT;
    if (w[15:10] == AALU_TOP6_ADD_FILE) return AALU_OP_ADD_FILE;
    if (w[15:10] == AALU_TOP6_ADD_CARRY) return AALU_OP_ADD_CARRY;
    return AALU_OP_NONE;
  endfunction

  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank);
    // Access bank limited to bank zero here; split access bank is core-level
    return w[AALU_ACCESS_BIT] ? {bank, w[7:0]} : {AALU_ACCESS_BANK, w[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aalu_phase_e ph_q, ph_d;
  aalu_op_e op_q, op_d;
  logic [15:0] iw_q, iw_d;
  logic [7:0] opnd_q, opnd_d;
  logic [8:0] sum_q, sum_d;
  aalu_flags_s fl_q, fl_d;
  logic [7:0] acc_q, acc_d;
  logic fwe_q, fwe_d;
  logic re_q, re_d;
  logic [11:0] ra_q, ra_d;
  aalu_wr_s wr_q, wr_d;
  logic [4:0] lo_sum;
  logic cin;

  always_comb begin
    ph_d = ph_q;
    op_d = op_q;
    iw_d = iw_q;
    opnd_d = opnd_q;
    sum_d = sum_q;
    fl_d = fl_q;
    acc_d = acc_q;
    fwe_d = 1'b0;
    re_d = 1'b0;
    ra_d = ra_q;
    wr_d = '0;
    cin = (op_q == AALU_OP_ADD_CARRY) ? flags_in.carry : 1'b0;
    lo_sum = 5'({1'b0, acc_q[3:0]}) + 5'({1'b0, opnd_q[3:0]}) + 5'(cin);
    unique case (ph_q)
      AALU_PH_DECODE: begin
        iw_d = instr_word;
        op_d = decode_op(instr_word);
        ra_d = file_addr(instr_word, bank_select_value);
        re_d = (decode_op(instr_word) == AALU_OP_ADD_FILE) ||
               (decode_op(instr_word) == AALU_OP_ADD_CARRY);
        ph_d = AALU_PH_READ;
      end
      AALU_PH_READ: begin
        opnd_d = (op_q == AALU_OP_ADD_FILE || op_q == AALU_OP_ADD_CARRY) ?
                 mem_rdata : iw_q[7:0];
        ph_d = AALU_PH_PROCESS;
      end
      AALU_PH_PROCESS: begin
        fl_d = flags_in;
        if (op_q == AALU_OP_AND_LIT) begin
          sum_d = {1'b0, acc_q & opnd_q};
        end else begin
          sum_d = 9'({1'b0, acc_q}) + 9'({1'b0, opnd_q}) + 9'(cin);
          fl_d.carry = sum_d[8];
          fl_d.digit_carry_flag = lo_sum[4];
          fl_d.overflow_flag = (acc_q[7] == opnd_q[7]) && (sum_d[7] != acc_q[7]);
        end
        fl_d.negative = sum_d[7];
        fl_d.zero = (sum_d[7:0] == 8'h00);
        ph_d = AALU_PH_WRITE;
      end
      AALU_PH_WRITE: begin
        if (op_q != AALU_OP_NONE) begin
          fwe_d = 1'b1;
          if ((op_q == AALU_OP_ADD_FILE || op_q == AALU_OP_ADD_CARRY) &&
              iw_q[AALU_DEST_BIT]) begin
            wr_d.en = 1'b1;
            wr_d.addr = ra_q;
            wr_d.data = sum_q[7:0];
          end else begin
            acc_d = sum_q[7:0];
          end
        end
        ph_d = AALU_PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph_q <= AALU_PH_DECODE;
      op_q <= AALU_OP_NONE;
      iw_q <= 16'h0000;
      opnd_q <= 8'h00;
      sum_q <= 9'h000;
      fl_q <= '0;
      acc_q <= AALU_ACC_RESET;
      fwe_q <= 1'b0;
      re_q <= 1'b0;
      ra_q <= 12'h000;
      wr_q <= '0;
    end else begin
      ph_q <= ph_d;
      op_q <= op_d;
      iw_q <= iw_d;
      opnd_q <= opnd_d;
      sum_q <= sum_d;
      fl_q <= fl_d;
      acc_q <= acc_d;
      fwe_q <= fwe_d;
      re_q <= re_d;
      ra_q <= ra_d;
      wr_q <= wr_d;
    end
  end

  assign flags_out = fl_q;
  assign flags_we = fwe_q;
  assign mem_raddr = ra_q;
  assign mem_re = re_q;
  assign mem_wr = wr_q;
  assign working_accumulator = acc_q;
  assign phase = 2'(ph_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_decode_add_lit;
    ph_q == AALU_PH_DECODE && instr_word[15:8] == AALU_TOP_ADD_LIT;
  endsequence

  sequence s_write_add;
    ph_q == AALU_PH_WRITE &&
    (op_q == AALU_OP_ADD_LIT || op_q == AALU_OP_ADD_FILE || op_q == AALU_OP_ADD_CARRY);
  endsequence

  a_add_lit_sum: assert property (s_decode_add_lit |-> ##4 (acc_q ==
      8'($past(acc_q, 4) + $past(instr_word[7:0], 4))))
    else $error("add literal result wrong");
  a_and_lit_acc: assert property (ph_q == AALU_PH_DECODE &&
      instr_word[15:8] == AALU_TOP_AND_LIT
      |-> ##4 acc_q == ($past(acc_q, 4) & $past(instr_word[7:0], 4)))
    else $error("and literal result wrong");
  a_and_keeps_carry: assert property (ph_q == AALU_PH_DECODE &&
      instr_word[15:8] == AALU_TOP_AND_LIT |-> ##3 fl_q.carry == $past(flags_in.carry))
    else $error("and literal changed carry");
  a_and_keeps_ovf: assert property (ph_q == AALU_PH_DECODE &&
      instr_word[15:8] == AALU_TOP_AND_LIT |-> ##3
      {fl_q.overflow_flag, fl_q.digit_carry_flag} ==
      {$past(flags_in.overflow_flag), $past(flags_in.digit_carry_flag)})
    else $error("and literal changed overflow or digit carry");
  a_phase_cycle: assert property (ph_q == AALU_PH_DECODE |-> ##4 ph_q == AALU_PH_DECODE)
    else $error("phase cycle not four");
  a_none_quiet: assert property (ph_q == AALU_PH_WRITE && op_q == AALU_OP_NONE |=>
      !flags_we && !mem_wr.en && $stable(acc_q))
    else $error("unrecognised word had an effect");
  a_file_read_addr: assert property (ph_q == AALU_PH_DECODE &&
      instr_word[15:10] == AALU_TOP6_ADD_FILE && !instr_word[AALU_ACCESS_BIT]
      |=> mem_re && mem_raddr[11:8] == AALU_ACCESS_BANK)
    else $error("access bank address wrong");
  a_file_dest_write: assert property (ph_q == AALU_PH_DECODE &&
      instr_word[15:10] == AALU_TOP6_ADD_FILE && instr_word[AALU_DEST_BIT]
      |-> ##4 mem_wr.en && $stable(acc_q))
    else $error("file destination not written");
  a_add_file_sum: assert property (ph_q == AALU_PH_PROCESS && op_q == AALU_OP_ADD_FILE
      |=> sum_q[7:0] == 8'($past(acc_q) + $past(opnd_q)))
    else $error("add file sum wrong");
  a_lit_no_carry: assert property (ph_q == AALU_PH_PROCESS &&
      op_q == AALU_OP_ADD_LIT |=>
      {fl_q.carry, sum_q[7:0]} == 9'({1'b0, $past(acc_q)}) + 9'({1'b0, $past(opnd_q)}))
    else $error("add literal carry wrong");
  a_carry_in: assert property (ph_q == AALU_PH_PROCESS && op_q == AALU_OP_ADD_CARRY
      |=> sum_q == 9'({1'b0, $past(acc_q)}) + 9'({1'b0, $past(opnd_q)})
          + 9'($past(flags_in.carry)))
    else $error("carry sum wrong");
  a_zero_flag: assert property (ph_q == AALU_PH_WRITE && op_q != AALU_OP_NONE
      |-> fl_q.zero == (sum_q[7:0] == 8'h00) && fl_q.negative == sum_q[7])
    else $error("zero or negative flag wrong");
  // Carry into a bit is sum xor both operands, so the adder is checked apart
  a_digit_carry: assert property (s_write_add |->
      fl_q.digit_carry_flag == (sum_q[4] ^ acc_q[4] ^ opnd_q[4]))
    else $error("digit carry flag wrong");
  a_signed_ovf: assert property (s_write_add |->
      fl_q.overflow_flag == (sum_q[8] ^ sum_q[7] ^ acc_q[7] ^ opnd_q[7]))
    else $error("overflow flag wrong");

endmodule // aalu_slice

// ==== bench/aalu_testbench.sv ====
// Purpose: Self-checking bench for the add/AND execution slice
// Assumes: One instruction per four clocks, inputs driven on falling edge
// Notes: Off-phase inputs are inverted to catch sampling in the wrong phase
`timescale 1ns/100ps
module testbench
  import aalu_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] instr;
    logic [3:0] bank;
    logic [7:0] rdata;
    aalu_flags_s flin;
    logic ok;
    logic [7:0] res;
    aalu_flags_s fl;
  } aalu_row_s;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_value = 4'h0;
  logic [7:0] mem_rdata = 8'h00;
  aalu_flags_s flags_in = '0;
  aalu_flags_s flags_out;
  logic flags_we;
  logic mem_re;
  logic [11:0] mem_raddr;
  aalu_wr_s mem_wr;
  logic [7:0] working_accumulator;
  logic [1:0] phase;
  logic [7:0] exp_acc = 8'h00;
  int n_mismatch = 0;
  int n_compared = 0;
  // Accumulator carries over from row to row
  aalu_row_s rows [12] = '{
    '{16'h0f10, 4'h0, 8'h00, 5'h00, 1'b1, 8'h10, 5'h00},
    '{16'h0f15, 4'h0, 8'h00, 5'h00, 1'b1, 8'h25, 5'h00},
    '{16'h24c2, 4'h5, 8'hc2, 5'h00, 1'b1, 8'he7, 5'h10},
    '{16'h2740, 4'h3, 8'h19, 5'h01, 1'b1, 8'h00, 5'h07},
    '{16'h2005, 4'h9, 8'h18, 5'h01, 1'b1, 8'h00, 5'h07},
    '{16'h0f7f, 4'h0, 8'h00, 5'h00, 1'b1, 8'h7f, 5'h00},
    '{16'h0f01, 4'h0, 8'h00, 5'h00, 1'b1, 8'h80, 5'h1a},
    '{16'h23ff, 4'hf, 8'h80, 5'h01, 1'b1, 8'h01, 5'h09},
    '{16'h0b5f, 4'h0, 8'h00, 5'h1f, 1'b1, 8'h00, 5'h0f},
    '{16'h0fa3, 4'h0, 8'h00, 5'h01, 1'b1, 8'ha3, 5'h10},
    '{16'h0b5f, 4'h0, 8'h00, 5'h00, 1'b1, 8'h03, 5'h00},
    '{16'h0e12, 4'h0, 8'h00, 5'h00, 1'b0, 8'h00, 5'h00}
  };

  always #5 clk_sys = ~clk_sys;

  aalu_slice u_aalu_slice (
    .clk_sys(clk_sys), .rst(rst), .instr_word(instr_word),
    .bank_select_value(bank_select_value), .mem_rdata(mem_rdata),
    .flags_in(flags_in), .flags_out(flags_out), .flags_we(flags_we),
    .mem_raddr(mem_raddr), .mem_re(mem_re), .mem_wr(mem_wr),
    .working_accumulator(working_accumulator), .phase(phase)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Entered at a falling edge in phase 0; returns at the next phase 0
  task automatic run(input aalu_row_s r);
    logic fop;
    logic [11:0] adr;
    fop = (r.instr[15:11] == 5'b00100);
    adr = {(r.instr[8] ? r.bank : AALU_ACCESS_BANK), r.instr[7:0]};
    instr_word = r.instr;
    bank_select_value = r.bank;
    mem_rdata = ~r.rdata;
    flags_in = ~r.flin;
    chk("phase", 21'(phase), 21'(2'h0));
    @(negedge clk_sys);
    chk("phase", 21'(phase), 21'(2'h1));
    chk("mem_re", 21'(mem_re), 21'(fop));
    if (fop) chk("mem_raddr", 21'(mem_raddr), 21'(adr));
    instr_word = ~r.instr;
    bank_select_value = ~r.bank;
    mem_rdata = r.rdata;
    @(negedge clk_sys);
    chk("phase", 21'(phase), 21'(2'h2));
    mem_rdata = ~r.rdata;
    flags_in = r.flin;
    @(negedge clk_sys);
    chk("phase", 21'(phase), 21'(2'h3));
    flags_in = ~r.flin;
    @(negedge clk_sys);
    if (r.ok && !(fop && r.instr[9])) exp_acc = r.res;
    chk("acc", 21'(working_accumulator), 21'(exp_acc));
    chk("flags_we", 21'(flags_we), 21'(r.ok));
    if (r.ok) chk("flags_out", 21'(flags_out), 21'(r.fl));
    chk("wr_en", 21'(mem_wr.en), 21'(fop & r.instr[9]));
    if (mem_wr.en) chk("wr", 21'({mem_wr.addr, mem_wr.data}), 21'({adr, r.res}));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    foreach (rows[i]) run(rows[i]);
    // Reset in mid-instruction must abandon it
    instr_word = 16'h0f44;
    repeat (2) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("rst", 21'({working_accumulator, phase, flags_we, mem_re, flags_out}), 21'h0);
    chk("rst_addr", 21'({mem_wr.en, mem_raddr}), 21'h0);
    rst = 1'b0;
    exp_acc = 8'h00;
    run('{16'h0f01, 4'h0, 8'h00, 5'h00, 1'b1, 8'h01, 5'h00});
    test_done();
  end
endmodule // testbench
